/* src/adctcb_pkg.sv */
// Constants, field layout and types of the ADC trim coefficient bank.
//
// Contract
// - Byte 0x5C bits 7-6 return order-2 offset coefficient bits 1-0.
// - Byte 0x5D returns order-2 offset coefficient bits 9-2, MSB in bit 7.
// - Byte 0x5E bits 1-0 return order-2 offset bits 11-10; bits 7-2 read zero.
// - Byte 0x5F returns order-0 gain coefficient bits 7-0, MSB in bit 7.
// - Byte 0x60 bit 7 returns order-1 gain coefficient bit 0.
// - Byte 0x60 bits 6-0 return order-0 gain bits 14-8; coefficient is 15 bits.
// - Byte 0x61 returns order-1 gain coefficient bits 8-1, MSB in bit 7.
// - Byte 0x5B returns order-1 offset bits 5-0, completing the 12-bit value.
// - Byte 0x62 low five bits return order-1 gain coefficient bits 13-9.
package adctcb_pkg;

    // ========================================================================
    // Bus geometry.
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int BYTE_W = 8;
    localparam int IDX_W = 8;
    localparam int ALIGN_W = 2;

    // ========================================================================
    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_SET1_K = 8'h5b;
    localparam logic [IDX_W-1:0] IDX_SET1_L = 8'h5c;
    localparam logic [IDX_W-1:0] IDX_SET1_M = 8'h5d;
    localparam logic [IDX_W-1:0] IDX_SET1_N = 8'h5e;
    localparam logic [IDX_W-1:0] IDX_SET2_A = 8'h5f;
    localparam logic [IDX_W-1:0] IDX_SET2_B = 8'h60;
    localparam logic [IDX_W-1:0] IDX_SET2_C = 8'h61;
    localparam logic [IDX_W-1:0] IDX_SET2_D = 8'h62;

    // ========================================================================
    // Coefficient widths and the bit positions where they split across bytes.
    localparam int OFS_W = 12;
    localparam int GAIN0_W = 15;
    localparam int GAIN1_W = 14;
    localparam int OFS1_SPLIT = 6;
    localparam int OFS2_SPLIT_LO = 2;
    localparam int OFS2_SPLIT_HI = 10;
    localparam int GAIN0_SPLIT = 8;
    localparam int GAIN1_SPLIT_LO = 1;
    localparam int GAIN1_SPLIT_HI = 9;

    // ========================================================================
    // Reset values.
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;

    // ========================================================================
    // Bus answer sequencer.
    typedef enum logic [1:0] {
        ACK_IDLE = 2'b01,
        ACK_DONE = 2'b10
    } adctcb_ack_t;

endpackage

/* src/adctcb_top.sv */
// Read-only ADC trim coefficient bank behind an Avalon-MM slave with waitrequest.
//
// Our own choice: the Avalon-MM interface to the registers.
module adctcb_top (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [adctcb_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [adctcb_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [adctcb_pkg::BE_W-1:0] avs_byteenable,
    output logic [adctcb_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic trim_load,
    input wire logic [adctcb_pkg::OFS_W-1:0] trim_offset_order1,
    input wire logic [adctcb_pkg::OFS_W-1:0] trim_offset_order2,
    input wire logic [adctcb_pkg::GAIN0_W-1:0] trim_gain_order0,
    input wire logic [adctcb_pkg::GAIN1_W-1:0] trim_gain_order1,
    output logic coeff_valid
);

    // ========================================================================
    // Reset release through two flip-flops.
    logic rst_meta_reg;
    logic rst_n_sync;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_sync <= rst_meta_reg;
        end
    end

    // ========================================================================
    // Coefficient storage, written only by the factory load strobe.
    logic [adctcb_pkg::OFS_W-1:0] offset_coeff_order1_reg;
    logic [adctcb_pkg::OFS_W-1:0] offset_coeff_order2_reg;
    logic [adctcb_pkg::GAIN0_W-1:0] gain_coeff_order0_reg;
    logic [adctcb_pkg::GAIN1_W-1:0] gain_coeff_order1_reg;
    logic coeff_valid_reg;

    // Bus writes are never steered here, so the bank stays read-only.
    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            offset_coeff_order1_reg <= '0;
            offset_coeff_order2_reg <= '0;
            gain_coeff_order0_reg <= '0;
            gain_coeff_order1_reg <= '0;
            coeff_valid_reg <= 1'b0;
        end else if (trim_load) begin
            offset_coeff_order1_reg <= trim_offset_order1;
            offset_coeff_order2_reg <= trim_offset_order2;
            gain_coeff_order0_reg <= trim_gain_order0;
            gain_coeff_order1_reg <= trim_gain_order1;
            coeff_valid_reg <= 1'b1;
        end
    end

    assign coeff_valid = coeff_valid_reg;

    // ========================================================================
    // Byte images of the bank. Neighbouring fields held by other banks read zero.
    wire [adctcb_pkg::BYTE_W-1:0] set1_trim_byte_k;
    wire [adctcb_pkg::BYTE_W-1:0] set1_trim_byte_l;
    wire [adctcb_pkg::BYTE_W-1:0] set1_trim_byte_m;
    wire [adctcb_pkg::BYTE_W-1:0] set1_trim_byte_n;
    wire [adctcb_pkg::BYTE_W-1:0] set2_trim_byte_a;
    wire [adctcb_pkg::BYTE_W-1:0] set2_trim_byte_b;
    wire [adctcb_pkg::BYTE_W-1:0] set2_trim_byte_c;
    wire [adctcb_pkg::BYTE_W-1:0] set2_trim_byte_d;

    assign set1_trim_byte_k = {offset_coeff_order1_reg[adctcb_pkg::OFS1_SPLIT-1:0],
        {(adctcb_pkg::BYTE_W - adctcb_pkg::OFS1_SPLIT){1'b0}}};
    assign set1_trim_byte_l = {
        offset_coeff_order2_reg[adctcb_pkg::OFS2_SPLIT_LO-1:0],
        offset_coeff_order1_reg[adctcb_pkg::OFS_W-1:adctcb_pkg::OFS1_SPLIT]};
    assign set1_trim_byte_m =
        offset_coeff_order2_reg[adctcb_pkg::OFS2_SPLIT_HI-1:adctcb_pkg::OFS2_SPLIT_LO];
    assign set1_trim_byte_n = {
        {(adctcb_pkg::BYTE_W - (adctcb_pkg::OFS_W - adctcb_pkg::OFS2_SPLIT_HI)){1'b0}},
        offset_coeff_order2_reg[adctcb_pkg::OFS_W-1:adctcb_pkg::OFS2_SPLIT_HI]};
    assign set2_trim_byte_a = gain_coeff_order0_reg[adctcb_pkg::GAIN0_SPLIT-1:0];
    assign set2_trim_byte_b = {
        gain_coeff_order1_reg[adctcb_pkg::GAIN1_SPLIT_LO-1:0],
        gain_coeff_order0_reg[adctcb_pkg::GAIN0_W-1:adctcb_pkg::GAIN0_SPLIT]};
    assign set2_trim_byte_c =
        gain_coeff_order1_reg[adctcb_pkg::GAIN1_SPLIT_HI-1:adctcb_pkg::GAIN1_SPLIT_LO];
    assign set2_trim_byte_d = {
        {(adctcb_pkg::BYTE_W - (adctcb_pkg::GAIN1_W - adctcb_pkg::GAIN1_SPLIT_HI)){1'b0}},
        gain_coeff_order1_reg[adctcb_pkg::GAIN1_W-1:adctcb_pkg::GAIN1_SPLIT_HI]};

    // ========================================================================
    // Address decode. Only word-aligned addresses of the eight indices are mapped.
    wire [adctcb_pkg::IDX_W-1:0] bus_idx;
    wire bus_aligned;
    wire bus_req;
    wire bus_take;
    wire [adctcb_pkg::BYTE_W-1:0] sel_byte;

    assign bus_idx = avs_address[adctcb_pkg::ADDR_W-1:adctcb_pkg::ALIGN_W];
    assign bus_aligned = (avs_address[adctcb_pkg::ALIGN_W-1:0] == '0);
    assign bus_req = avs_read || avs_write;

    assign sel_byte = !bus_aligned ? adctcb_pkg::BYTE_RESET :
        (bus_idx == adctcb_pkg::IDX_SET1_K) ? set1_trim_byte_k :
        (bus_idx == adctcb_pkg::IDX_SET1_L) ? set1_trim_byte_l :
        (bus_idx == adctcb_pkg::IDX_SET1_M) ? set1_trim_byte_m :
        (bus_idx == adctcb_pkg::IDX_SET1_N) ? set1_trim_byte_n :
        (bus_idx == adctcb_pkg::IDX_SET2_A) ? set2_trim_byte_a :
        (bus_idx == adctcb_pkg::IDX_SET2_B) ? set2_trim_byte_b :
        (bus_idx == adctcb_pkg::IDX_SET2_C) ? set2_trim_byte_c :
        (bus_idx == adctcb_pkg::IDX_SET2_D) ? set2_trim_byte_d :
        adctcb_pkg::BYTE_RESET;

    // ========================================================================
    // Answer sequencer: one wait cycle, then waitrequest low for exactly one cycle.
    adctcb_pkg::adctcb_ack_t state_reg;
    adctcb_pkg::adctcb_ack_t state_next;
    logic wait_reg;
    logic [adctcb_pkg::DATA_W-1:0] rdata_reg;
    logic [adctcb_pkg::DATA_W-1:0] rdata_next;

    always_comb begin
        case (state_reg)
            adctcb_pkg::ACK_IDLE: begin
                state_next = bus_req ? adctcb_pkg::ACK_DONE : adctcb_pkg::ACK_IDLE;
            end
            adctcb_pkg::ACK_DONE: begin
                state_next = adctcb_pkg::ACK_IDLE;
            end
            default: begin
                state_next = adctcb_pkg::ACK_IDLE;
            end
        endcase
    end

    assign bus_take = (state_reg == adctcb_pkg::ACK_IDLE) && bus_req;
    assign rdata_next = (bus_take && avs_read) ?
        {{(adctcb_pkg::DATA_W - adctcb_pkg::BYTE_W){1'b0}}, sel_byte} : rdata_reg;

    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            state_reg <= adctcb_pkg::ACK_IDLE;
            wait_reg <= 1'b1;
            rdata_reg <= adctcb_pkg::WORD_RESET;
        end else begin
            state_reg <= state_next;
            wait_reg <= (state_next != adctcb_pkg::ACK_DONE);
            rdata_reg <= rdata_next;
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;

    // ========================================================================
    // Assertions.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n_sync);

    wire read_take;
    assign read_take = avs_read && avs_waitrequest && bus_aligned && !avs_write;

    a_l_offset2_low:
        assert property (read_take && bus_idx == 8'h5c |=>
            !avs_waitrequest && avs_readdata[7:6] == $past(offset_coeff_order2_reg[1:0]))
        else $error("Byte 0x5c top bits do not hold order-2 offset bits 1-0.");

    a_l_offset1_high:
        assert property (read_take && bus_idx == 8'h5c |=>
            avs_readdata[5:0] == $past(offset_coeff_order1_reg[11:6]))
        else $error("Byte 0x5c low bits do not hold order-1 offset bits 11-6.");

    a_m_offset2_mid:
        assert property (read_take && bus_idx == 8'h5d |=>
            avs_readdata[7:0] == $past(offset_coeff_order2_reg[9:2]))
        else $error("Byte 0x5d does not hold order-2 offset bits 9-2.");

    a_n_offset2_top:
        assert property (read_take && bus_idx == 8'h5e |=>
            avs_readdata[7:0] == {6'h00, $past(offset_coeff_order2_reg[11:10])})
        else $error("Byte 0x5e does not hold order-2 offset bits 11-10 over zeros.");

    a_a_gain0_low:
        assert property (read_take && bus_idx == 8'h5f |=>
            avs_readdata[7:0] == $past(gain_coeff_order0_reg[7:0]))
        else $error("Byte 0x5f does not hold order-0 gain bits 7-0.");

    a_b_gain1_bit0:
        assert property (read_take && bus_idx == 8'h60 |=>
            avs_readdata[7] == $past(gain_coeff_order1_reg[0]))
        else $error("Byte 0x60 bit 7 does not hold order-1 gain bit 0.");

    a_b_gain0_high:
        assert property (read_take && bus_idx == 8'h60 |=>
            avs_readdata[6:0] == $past(gain_coeff_order0_reg[14:8]))
        else $error("Byte 0x60 low bits do not hold order-0 gain bits 14-8.");

    a_c_gain1_mid:
        assert property (read_take && bus_idx == 8'h61 |=>
            avs_readdata[7:0] == $past(gain_coeff_order1_reg[8:1]))
        else $error("Byte 0x61 does not hold order-1 gain bits 8-1.");

    a_k_offset1_low:
        assert property (read_take && bus_idx == 8'h5b |=>
            avs_readdata[7:0] == {$past(offset_coeff_order1_reg[5:0]), 2'h0})
        else $error("Byte 0x5b does not hold order-1 offset bits 5-0.");

    a_d_gain1_top:
        assert property (read_take && bus_idx == 8'h62 |=>
            avs_readdata[7:0] == {3'h0, $past(gain_coeff_order1_reg[13:9])})
        else $error("Byte 0x62 does not hold order-1 gain bits 13-9.");

    a_zero_before_load:
        assert property (avs_read && avs_waitrequest && !coeff_valid && !avs_write |=>
            !avs_waitrequest && avs_readdata == 32'h0000_0000)
        else $error("A read before the coefficient load returned a nonzero word.");

    a_write_no_change:
        assert property (avs_write && avs_waitrequest && !trim_load |=>
            $stable(offset_coeff_order1_reg) && $stable(offset_coeff_order2_reg)
            && $stable(gain_coeff_order0_reg) && $stable(gain_coeff_order1_reg))
        else $error("A bus write changed the stored coefficients.");

    a_answer_single_cycle:
        assert property (bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("The bus answer did not come one cycle after the request.");

    a_upper_bits_zero:
        assert property (avs_readdata[31:8] == 24'h000000)
        else $error("Read data above the low byte is not zero.");

    a_unmapped_zero:
        assert property (read_take && (bus_idx < 8'h5b || bus_idx > 8'h62) |=>
            avs_readdata == 32'h0000_0000)
        else $error("An unmapped address returned a nonzero word.");

    // ========================================================================
    // Load, hold and handshake checks.
    a_load_sets_valid:
        assert property (trim_load |=> coeff_valid)
        else $error("The coefficient load did not raise the valid flag.");

    a_valid_holds:
        assert property (coeff_valid |=> coeff_valid)
        else $error("The valid flag fell without a reset.");

    a_load_stores_coeffs:
        assert property (trim_load |=>
            offset_coeff_order1_reg == $past(trim_offset_order1)
            && offset_coeff_order2_reg == $past(trim_offset_order2)
            && gain_coeff_order0_reg == $past(trim_gain_order0)
            && gain_coeff_order1_reg == $past(trim_gain_order1))
        else $error("The coefficient load did not store the presented values.");

    a_hold_without_load:
        assert property (!trim_load |=>
            $stable(offset_coeff_order1_reg) && $stable(offset_coeff_order2_reg)
            && $stable(gain_coeff_order0_reg) && $stable(gain_coeff_order1_reg))
        else $error("Stored coefficients changed without a load.");

    a_readdata_held:
        assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("Read data changed without a read being taken.");

    a_answer_then_wait:
        assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Waitrequest stayed low for more than one cycle.");

    a_no_request_no_answer:
        assert property (!bus_req && avs_waitrequest |=> avs_waitrequest)
        else $error("Waitrequest fell without a request.");

    a_idle_waits:
        assert property (state_reg == adctcb_pkg::ACK_IDLE |-> avs_waitrequest)
        else $error("Waitrequest was low while the sequencer was idle.");

    a_state_onehot:
        assert property ($onehot(state_reg))
        else $error("The answer sequencer left its one-hot codes.");

    a_unaligned_zero:
        assert property (avs_read && avs_waitrequest && !bus_aligned |=>
            avs_readdata == 32'h0000_0000)
        else $error("An unaligned read returned a nonzero word.");

    c_unaligned_read:
        cover property (avs_read && avs_waitrequest && !bus_aligned ##1 !avs_waitrequest);

    c_read_loaded:
        cover property (coeff_valid && read_take && bus_idx == 8'h60 ##1 !avs_waitrequest);

    c_write_ignored:
        cover property (avs_write && avs_waitrequest ##1 !avs_waitrequest);

    c_load_seen:
        cover property (trim_load ##1 coeff_valid);

    c_back_to_back:
        cover property (!avs_waitrequest && avs_read ##1 avs_read ##1 !avs_waitrequest);

endmodule

/* tb/adctcb_testbench.sv */
// Self-checking testbench for the ADC trim coefficient bank over its Avalon-MM slave.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    // ========================================================================
    // Stimulus and observed signals.
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [adctcb_pkg::ADDR_W-1:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [adctcb_pkg::DATA_W-1:0] avs_writedata = 32'h0000_0000;
    logic [adctcb_pkg::BE_W-1:0] avs_byteenable = 4'hf;
    logic [adctcb_pkg::DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic trim_load = 1'b0;
    logic [adctcb_pkg::OFS_W-1:0] trim_offset_order1 = 12'h000;
    logic [adctcb_pkg::OFS_W-1:0] trim_offset_order2 = 12'h000;
    logic [adctcb_pkg::GAIN0_W-1:0] trim_gain_order0 = 15'h0000;
    logic [adctcb_pkg::GAIN1_W-1:0] trim_gain_order1 = 14'h0000;
    logic coeff_valid;
    logic [11:0] e_o1 = 12'h000;
    logic [11:0] e_o2 = 12'h000;
    logic [14:0] e_g0 = 15'h0000;
    logic [13:0] e_g1 = 14'h0000;
    logic [31:0] rd;
    int error_cnt = 0;
    int tests_run = 0;

    adctcb_top dut (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .trim_load(trim_load),
        .trim_offset_order1(trim_offset_order1),
        .trim_offset_order2(trim_offset_order2),
        .trim_gain_order0(trim_gain_order0),
        .trim_gain_order1(trim_gain_order1),
        .coeff_valid(coeff_valid)
    );

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // ========================================================================
    // Comparison, verdict and expected byte images.
    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_flag(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    function automatic logic [31:0] exp_word(input logic [7:0] idx);
        logic [7:0] b;
        case (idx)
            8'h5b: b = {e_o1[5:0], 2'b00};
            8'h5c: b = {e_o2[1:0], e_o1[11:6]};
            8'h5d: b = e_o2[9:2];
            8'h5e: b = {6'b000000, e_o2[11:10]};
            8'h5f: b = e_g0[7:0];
            8'h60: b = {e_g1[0], e_g0[14:8]};
            8'h61: b = e_g1[8:1];
            8'h62: b = {3'b000, e_g1[13:9]};
            default: b = 8'h00;
        endcase
        return {24'h000000, b};
    endfunction

    // ========================================================================
    // Bus and load drivers; each is entered just after a rising edge.
    task automatic bus_xfer(input logic wr, input logic [9:0] addr, input logic [31:0] wdata,
                            output logic [31:0] rdata);
        int n;
        avs_address <= addr;
        avs_writedata <= wdata;
        avs_read <= ~wr;
        avs_write <= wr;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        check_word("answer_cycles", 32'h0000_0002, n);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic load(input logic [11:0] o1, input logic [11:0] o2, input logic [14:0] g0,
                        input logic [13:0] g1);
        trim_offset_order1 <= o1;
        trim_offset_order2 <= o2;
        trim_gain_order0 <= g0;
        trim_gain_order1 <= g1;
        trim_load <= 1'b1;
        @(posedge sys_clk);
        trim_load <= 1'b0;
        {e_o1, e_o2, e_g0, e_g1} = {o1, o2, g0, g1};
        @(posedge sys_clk);
    endtask

    task automatic check_all(input string tname);
        for (int i = 8'h5b; i <= 8'h62; i++) begin
            bus_xfer(1'b0, {i[7:0], 2'b00}, 32'h0, rd);
            check_word("readdata", exp_word(i[7:0]), rd);
        end
        $display("test %s done", tname);
    endtask

    task automatic do_reset;
        resetn <= 1'b0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        {e_o1, e_o2, e_g0, e_g1} = 53'h0;
    endtask

    // ========================================================================
    // Hang guard and main sequence.
    initial begin
        repeat (3000) @(posedge sys_clk);
        error_cnt++;
        $display("BAD timeout expected finish seen hang");
        summarize();
    end

    initial begin
        @(posedge sys_clk);
        do_reset();
        check_flag("coeff_valid", 1'b0, coeff_valid);
        check_all("reset_zero");
        load(12'ha5c, 12'h3c9, 15'h5a3c, 14'h2b6d);
        check_flag("coeff_valid", 1'b1, coeff_valid);
        check_all("pattern_a");
        load(~12'ha5c, ~12'h3c9, ~15'h5a3c, ~14'h2b6d);
        check_all("pattern_b");
        for (int i = 8'h5b; i <= 8'h62; i++) begin
            bus_xfer(1'b1, {i[7:0], 2'b00}, 32'hffff_ffff, rd);
        end
        bus_xfer(1'b1, {adctcb_pkg::IDX_SET1_N, 2'b00}, 32'h0000_0000, rd);
        check_all("write_ignored");
        bus_xfer(1'b0, 10'h000, 32'h0, rd);
        check_word("unmapped", 32'h0000_0000, rd);
        bus_xfer(1'b0, 10'h171, 32'h0, rd);
        check_word("unaligned", 32'h0000_0000, rd);
        bus_xfer(1'b0, 10'h18c, 32'h0, rd);
        check_word("above_bank", 32'h0000_0000, rd);
        $display("test unmapped done");
        do_reset();
        check_flag("coeff_valid", 1'b0, coeff_valid);
        check_all("second_reset");
        summarize();
    end
endmodule
